// ### inc/pcm_pkg.sv
package pcm_pkg;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned LINES = 16;
    localparam int unsigned IDX_W = 4;
    // Register byte addresses
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_MASK = 6'h04;
    localparam logic [5:0] OFF_WORD0 = 6'h08;
    localparam logic [5:0] OFF_WORD3 = 6'h14;
    localparam logic [5:0] OFF_LRU = 6'h18;
    localparam logic [5:0] OFF_HIT = 6'h1C;
    localparam logic [5:0] OFF_MISS = 6'h20;
    localparam logic [5:0] OFF_ABORT = 6'h24;
    // Control register fields
    localparam int unsigned CTRL_IDX_LSB = 0;
    localparam int unsigned CTRL_DATA_CACHE_SIZE_LSB = 4;
    localparam logic [3:0] MASK_LINE_A = 4'hA;
    localparam logic [3:0] MASK_LINE_B = 4'hB;
    localparam int unsigned MASK_LSB = 5;
    localparam int unsigned MASK_W = 11;
    localparam int unsigned LRU_W = 25;
    localparam logic [1:0] DATA_CACHE_SIZE_NONE = 2'h0;
    localparam logic [1:0] DATA_CACHE_SIZE_ONE = 2'h1;
    localparam logic [1:0] DATA_CACHE_SIZE_TWO = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### inc/pcm_mem_if.sv
`timescale 1ns/1ps
interface pcm_mem_if;
    logic we;
    logic [5:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ### verilog/pcm_data_ram.sv
`timescale 1ns/1ps
module pcm_data_ram (
    // Clock
    input wire logic aclk,
    // Port
    pcm_mem_if.mem port
);
    logic [31:0] mem_q [0:63];
    logic [31:0] rd_q;
    // Contents are unknown at power-on, so no reset
    always_ff @(posedge aclk) begin
        if (port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
        rd_q <= mem_q[port.addr];
    end
    assign port.rdata = rd_q;
endmodule

// ### verilog/pcm_regs.sv
`timescale 1ns/1ps
module pcm_regs #(
    parameter int unsigned TAG_W = 20
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [5:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [5:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Cache core status
    input wire logic code_protect,
    input wire logic [24:0] lru_state,
    input wire logic ev_hit,
    input wire logic ev_miss,
    input wire logic ev_cacheable,
    input wire logic ev_abort,
    // Tag compare for one line
    input wire logic [TAG_W-1:0] cmp_addr,
    input wire logic [TAG_W-1:0] cmp_tag,
    input wire logic [3:0] cmp_line,
    output logic cmp_match,
    // Data line reservation
    output logic [15:0] data_lines
);
    initial begin
        if (TAG_W < pcm_pkg::MASK_W + 1) begin
            $error("TAG_W too small for mask field");
        end
    end

    logic [3:0] idx_q;
    logic [1:0] data_cache_size_q;
    logic [10:0] mask_a_q, mask_b_q;
    logic [31:0] hit_q, miss_q, abort_q;
    logic [24:0] lru_q;
    logic aw_q, w_q;
    logic [5:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [5:0] araddr_q;
    logic rd_pend_q;
    logic rd_word_q, rd_prot_q;

    pcm_mem_if ram_if ();
    pcm_data_ram u_ram (.aclk(aclk), .port(ram_if));

    // Write path: address and data latch in either order
    wire aw_take = s_awvalid && s_awready;
    wire w_take = s_wvalid && s_wready;
    wire wr_go = aw_q && w_q && !s_bvalid;
    // Strobes are kept with the data so a partial write can be refused later
    logic [3:0] wstrb_q;
    wire full_strb = (wstrb_q == 4'hF);
    // Unmapped or partial writes answer SLVERR and must leave every register alone
    wire wr_ok = wr_go && wr_known && full_strb;
    wire is_word_wr = (awaddr_q >= pcm_pkg::OFF_WORD0) && (awaddr_q <= pcm_pkg::OFF_WORD3);
    wire mask_line_ok = (idx_q == pcm_pkg::MASK_LINE_A) || (idx_q == pcm_pkg::MASK_LINE_B);
    wire wr_ctrl = wr_ok && awaddr_q == pcm_pkg::OFF_CTRL;
    wire wr_mask = wr_ok && awaddr_q == pcm_pkg::OFF_MASK && mask_line_ok;
    wire wr_hit = wr_ok && awaddr_q == pcm_pkg::OFF_HIT;
    wire wr_miss = wr_ok && awaddr_q == pcm_pkg::OFF_MISS;
    wire wr_abort = wr_ok && awaddr_q == pcm_pkg::OFF_ABORT;
    wire wr_known = (awaddr_q <= pcm_pkg::OFF_ABORT) && (awaddr_q[1:0] == 2'h0);
    wire [10:0] wr_mask_val = wdata_q[pcm_pkg::MASK_LSB +: pcm_pkg::MASK_W];

    // Read port of the data RAM is shared; writes take precedence
    wire rd_take = s_arvalid && s_arready;
    wire is_word_rd = (s_araddr >= pcm_pkg::OFF_WORD0) && (s_araddr <= pcm_pkg::OFF_WORD3);
    wire [1:0] wr_wsel = awaddr_q[3:2] - 2'h2;
    wire [1:0] rd_wsel = s_araddr[3:2] - 2'h2;
    assign ram_if.we = wr_ok && is_word_wr;
    assign ram_if.addr = ram_if.we ? {idx_q, wr_wsel} : {idx_q, rd_wsel};
    assign ram_if.wdata = wdata_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 6'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= pcm_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            if (w_take) begin
                w_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (wr_known && full_strb) ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end
    assign s_awready = !aw_q;
    assign s_wready = !w_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_q <= 4'h0;
            data_cache_size_q <= pcm_pkg::DATA_CACHE_SIZE_NONE;
            mask_a_q <= 11'h000;
            mask_b_q <= 11'h000;
        end else begin
            if (wr_ctrl) begin
                idx_q <= wdata_q[pcm_pkg::CTRL_IDX_LSB +: 4];
                data_cache_size_q <= wdata_q[pcm_pkg::CTRL_DATA_CACHE_SIZE_LSB +: 2];
            end
            if (wr_mask && idx_q == pcm_pkg::MASK_LINE_A) begin
                mask_a_q <= wr_mask_val;
            end
            if (wr_mask && idx_q == pcm_pkg::MASK_LINE_B) begin
                mask_b_q <= wr_mask_val;
            end
        end
    end

    // Statistics counters: hit and miss count only cacheable events, abort counts every abort; software write wins
    wire inc_hit = ev_hit && ev_cacheable;
    wire inc_miss = ev_miss && ev_cacheable;
    // Cleared at reset so the counter checks never see unknown values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_q <= 32'h00000000;
            miss_q <= 32'h00000000;
            abort_q <= 32'h00000000;
        end else begin
        if (wr_hit) begin
            hit_q <= wdata_q;
        end else if (inc_hit) begin
            hit_q <= hit_q + 32'h00000001;
        end
        if (wr_miss) begin
            miss_q <= wdata_q;
        end else if (inc_miss) begin
            miss_q <= miss_q + 32'h00000001;
        end
        if (wr_abort) begin
            abort_q <= wdata_q;
        end else if (ev_abort) begin
            abort_q <= abort_q + 32'h00000001;
        end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lru_q <= 25'h0000000;
        end else begin
            lru_q <= lru_state;
        end
    end

    // Read path: one cycle to fetch the RAM word, then answer
    wire [10:0] cur_mask = (idx_q == pcm_pkg::MASK_LINE_A) ? mask_a_q :
                           (idx_q == pcm_pkg::MASK_LINE_B) ? mask_b_q : 11'h000;
    logic [31:0] reg_rd;
    always_comb begin
        reg_rd = 32'h00000000;
        case (araddr_q)
            pcm_pkg::OFF_CTRL: reg_rd = {26'h0, data_cache_size_q, idx_q};
            pcm_pkg::OFF_MASK: reg_rd = {16'h0, cur_mask, 5'h00};
            pcm_pkg::OFF_LRU: reg_rd = {7'h00, lru_q};
            pcm_pkg::OFF_HIT: reg_rd = hit_q;
            pcm_pkg::OFF_MISS: reg_rd = miss_q;
            pcm_pkg::OFF_ABORT: reg_rd = abort_q;
            default: reg_rd = 32'h00000000;
        endcase
    end
    wire rd_known = (araddr_q <= pcm_pkg::OFF_ABORT) && (araddr_q[1:0] == 2'h0);
    assign s_arready = !rd_pend_q && !s_rvalid && !ram_if.we;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend_q <= 1'b0;
            araddr_q <= 6'h00;
            rd_word_q <= 1'b0;
            rd_prot_q <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= pcm_pkg::RESP_OKAY;
        end else begin
            if (rd_take) begin
                rd_pend_q <= 1'b1;
                araddr_q <= s_araddr;
                rd_word_q <= is_word_rd && (s_araddr[1:0] == 2'h0);
                rd_prot_q <= code_protect;
            end
            if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                s_rvalid <= 1'b1;
                if (rd_word_q) begin
                    s_rdata <= rd_prot_q ? 32'h00000000 : ram_if.rdata;
                    s_rresp <= rd_prot_q ? pcm_pkg::RESP_SLVERR : pcm_pkg::RESP_OKAY;
                end else begin
                    s_rdata <= reg_rd;
                    s_rresp <= rd_known ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
                end
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // Tag compare with per-line mask over address bits 15:5
    logic [TAG_W-1:0] cmp_mask;
    always_comb begin
        cmp_mask = '0;
        if (cmp_line == pcm_pkg::MASK_LINE_A) begin
            cmp_mask[11:1] = mask_a_q;
        end else if (cmp_line == pcm_pkg::MASK_LINE_B) begin
            cmp_mask[11:1] = mask_b_q;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_match <= 1'b0;
        end else begin
            cmp_match <= ((cmp_addr ^ cmp_tag) & ~cmp_mask) == '0;
        end
    end

    // Lines reserved for program-flash data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_lines <= 16'h0000;
        end else begin
            unique case (data_cache_size_q)
                pcm_pkg::DATA_CACHE_SIZE_NONE: data_lines <= 16'h0000;
                pcm_pkg::DATA_CACHE_SIZE_ONE: data_lines <= 16'h8000;
                pcm_pkg::DATA_CACHE_SIZE_TWO: data_lines <= 16'hC000;
                default: data_lines <= 16'hF000;
            endcase
        end
    end

    mask_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && awaddr_q == pcm_pkg::OFF_MASK && !mask_line_ok)
        |=> $stable(mask_a_q) && $stable(mask_b_q))
        else $error("mask written for other line");
    hit_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (inc_hit && !wr_hit) |=> hit_q == $past(hit_q) + 32'h00000001)
        else $error("hit counter missed increment");
    noncache_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ev_cacheable && !wr_hit && !wr_miss) |=> $stable(hit_q) && $stable(miss_q))
        else $error("non-cacheable access counted");
    miss_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (inc_miss && !wr_miss) |=> miss_q == $past(miss_q) + 32'h00000001)
        else $error("miss counter missed increment");
    abort_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ev_abort && !wr_abort) |=> abort_q == $past(abort_q) + 32'h00000001)
        else $error("abort counter missed increment");
    sw_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_hit |=> hit_q == $past(wdata_q))
        else $error("hit counter write lost");
    protect_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_take && is_word_rd && code_protect) |-> ##2 (s_rvalid && s_rdata == 32'h00000000))
        else $error("protected word leaked");
    data_size_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (data_cache_size_q == 2'h3) |=> data_lines == 16'hF000)
        else $error("data lines wrong for size 3");
endmodule

// ### sim/pcm_core_model.sv
`timescale 1ns/1ps
module pcm_core_model (
    // Clock
    input wire logic aclk,
    // Request from bench: kind bit0 hit, bit1 miss, bit2 abort, bit3 cacheable
    input wire logic go,
    input wire logic [3:0] kind,
    input wire logic [24:0] lru_in,
    // Cache core events
    output logic ev_hit,
    output logic ev_miss,
    output logic ev_cacheable,
    output logic ev_abort,
    output logic [24:0] lru_state
);
    initial begin
        ev_hit = 1'b0;
        ev_miss = 1'b0;
        ev_abort = 1'b0;
        ev_cacheable = 1'b0;
        lru_state = 25'h0;
    end

    // Outside events the region qualifier wanders, so only the event cycle may count
    always_ff @(posedge aclk) begin
        ev_hit <= go & kind[0];
        ev_miss <= go & kind[1];
        ev_abort <= go & kind[2];
        ev_cacheable <= go ? kind[3] : ~ev_cacheable;
        lru_state <= lru_in;
    end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, code_protect = 0;
    logic bready = 1, rready = 1, go = 0;
    logic awready, wready, bvalid, arready, rvalid, ev_hit, ev_miss, ev_cacheable, ev_abort;
    logic cmp_match;
    logic [5:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hF, kind = 0, cmp_line = 0;
    logic [1:0] bresp, rresp, r;
    logic [24:0] lru_in = 0, lru_state;
    logic [19:0] cmp_addr = 0, cmp_tag = 0;
    logic [15:0] data_lines;
    int error_cnt = 0, cmp_count = 0;

    always #5 aclk = ~aclk;

    pcm_core_model core (.aclk(aclk), .go(go), .kind(kind), .lru_in(lru_in), .ev_hit(ev_hit),
        .ev_miss(ev_miss), .ev_cacheable(ev_cacheable), .ev_abort(ev_abort),
        .lru_state(lru_state));

    pcm_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .code_protect(code_protect),
        .lru_state(lru_state), .ev_hit(ev_hit), .ev_miss(ev_miss),
        .ev_cacheable(ev_cacheable), .ev_abort(ev_abort), .cmp_addr(cmp_addr),
        .cmp_tag(cmp_tag), .cmp_line(cmp_line), .cmp_match(cmp_match),
        .data_lines(data_lines));

    task automatic final_report;
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask

    // Ready lines stay high, so the answer is taken at the edge where valid is seen
    task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rsp);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 60);
        rsp = bresp;
        if (n >= 60) begin
            error_cnt++;
            final_report();
        end
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rsp);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 60);
        v = rdata;
        rsp = rresp;
        if (n >= 60) begin
            error_cnt++;
            final_report();
        end
    endtask

    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, pcm_pkg::RESP_OKAY});
    endtask

    task automatic cmpq(input logic [3:0] ln, input logic [19:0] ad, input logic e);
        cmp_line <= ln;
        cmp_addr <= ad;
        repeat (2) @(posedge aclk);
        chk({31'h0, cmp_match}, {31'h0, e});
    endtask

    task automatic ev(input logic [3:0] k);
        go <= 1'b1;
        kind <= k;
        @(posedge aclk);
        go <= 1'b0;
        @(posedge aclk);
    endtask

    logic [15:0] lines_exp [4] = '{16'h0000, 16'h8000, 16'hC000, 16'hF000};

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        wr(pcm_pkg::OFF_CTRL, 32'h0000000A, r);
        wr(pcm_pkg::OFF_MASK, 32'h0000FFE0, r);
        rc(pcm_pkg::OFF_MASK, 32'h0000FFE0);
        cmpq(4'hA, 20'h00FFE, 1'b1);
        cmpq(4'hA, 20'h01FFE, 1'b0);
        wr(pcm_pkg::OFF_CTRL, 32'h00000003, r);
        wr(pcm_pkg::OFF_MASK, 32'h000000E0, r);
        rc(pcm_pkg::OFF_MASK, 32'h00000000);
        cmpq(4'h3, 20'h00FFE, 1'b0);
        wr(pcm_pkg::OFF_CTRL, 32'h0000000A, r);
        rc(pcm_pkg::OFF_MASK, 32'h0000FFE0);
        wr(pcm_pkg::OFF_CTRL, 32'h00000005, r);
        for (int i = 0; i < 4; i++) wr(pcm_pkg::OFF_WORD0 + 6'(4 * i), 32'hA5C30000 + i, r);
        for (int i = 0; i < 4; i++) rc(pcm_pkg::OFF_WORD0 + 6'(4 * i), 32'hA5C30000 + i);
        code_protect <= 1'b1;
        rd(pcm_pkg::OFF_WORD3, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, pcm_pkg::RESP_SLVERR});
        code_protect <= 1'b0;
        lru_in <= 25'h1ABCDEF;
        // The state passes the core model and the sampling flop before it is readable
        repeat (3) @(posedge aclk);
        rc(pcm_pkg::OFF_LRU, 32'h01ABCDEF);
        wr(pcm_pkg::OFF_HIT, 32'h0, r);
        wr(pcm_pkg::OFF_MISS, 32'h0, r);
        wr(pcm_pkg::OFF_ABORT, 32'hFFFFFFFF, r);
        repeat (3) ev(4'b1001);
        repeat (2) ev(4'b0001);
        repeat (2) ev(4'b1010);
        ev(4'b0010);
        ev(4'b0100);
        rc(pcm_pkg::OFF_HIT, 32'd3);
        rc(pcm_pkg::OFF_MISS, 32'd2);
        rc(pcm_pkg::OFF_ABORT, 32'd0);
        wstrb <= 4'h3;
        wr(pcm_pkg::OFF_HIT, 32'h00000055, r);
        wstrb <= 4'hF;
        chk({30'h0, r}, {30'h0, pcm_pkg::RESP_SLVERR});
        rc(pcm_pkg::OFF_HIT, 32'd3);
        for (int k = 0; k < 4; k++) begin
            wr(pcm_pkg::OFF_CTRL, 32'(k) << 4, r);
            repeat (2) @(posedge aclk);
            chk({16'h0, data_lines}, {16'h0, lines_exp[k]});
        end
        rd(6'h3C, d, r);
        chk({30'h0, r}, {30'h0, pcm_pkg::RESP_SLVERR});
        wr(6'h3C, 32'h0, r);
        chk({30'h0, r}, {30'h0, pcm_pkg::RESP_SLVERR});
        final_report();
    end
endmodule
